// ### core/smie_defines.vh
`ifndef SMIE_DEFINES_VH
`define SMIE_DEFINES_VH

// operation codes presented on OP_CODE
`define SMIE_OP_NONE        3'h0
`define SMIE_OP_SHIFT_RIGHT 3'h1
`define SMIE_OP_COPY_FILE   3'h2
`define SMIE_OP_INDIRECT_LD 3'h3
`define SMIE_OP_BANK_LIT    3'h4
`define SMIE_OP_PAGE_LIT    3'h5
`define SMIE_OP_ACC_LIT     3'h6

// pointer update codes
`define SMIE_MODE_PRE_INC   2'h0
`define SMIE_MODE_PRE_DEC   2'h1
`define SMIE_MODE_POST_INC  2'h2
`define SMIE_MODE_POST_DEC  2'h3

// destination select values
`define SMIE_DEST_ACC       1'h0
`define SMIE_DEST_FILE      1'h1

// direct file addresses that act as indirect windows
`define SMIE_WINDOW0_ADDR   7'h00
`define SMIE_WINDOW1_ADDR   7'h01

// software register offsets
`define SMIE_REG_ACC        4'h0
`define SMIE_REG_STATUS     4'h1
`define SMIE_REG_BANK       4'h2
`define SMIE_REG_PAGE       4'h3
`define SMIE_REG_PTR0_LO    4'h4
`define SMIE_REG_PTR0_HI    4'h5
`define SMIE_REG_PTR1_LO    4'h6
`define SMIE_REG_PTR1_HI    4'h7
`define SMIE_REG_MADDR_LO   4'h8
`define SMIE_REG_MADDR_HI   4'h9
`define SMIE_REG_MDATA      4'hA

// status field positions
`define SMIE_STAT_CARRY     0
`define SMIE_STAT_ZERO      1

// reset values
`define SMIE_RST_ACC        8'h00
`define SMIE_RST_BANK       5'h00
`define SMIE_RST_PAGE       7'h00
`define SMIE_RST_PTR        16'h0000
`define SMIE_RST_FLAG       1'h0

`endif

// ### core/smie_ptr_unit.v
`timescale 1ns/1ps
`include "smie_defines.vh"

// effective address and next pointer value for one indirect access
module smie_ptr_unit (
    input  wire [15:0] ptr,
    input  wire [1:0]  mode,
    input  wire        rel,
    input  wire [5:0]  offset,
    output reg  [15:0] eff_addr,
    output reg  [15:0] ptr_next
);
    wire [15:0] ptr_inc;  // wraps FFFFh to 0000h by 16-bit truncation
    wire [15:0] ptr_dec;  // wraps 0000h to FFFFh
    wire [15:0] ptr_rel;  // signed offset, -32 to 31

    assign ptr_inc = ptr + 16'h0001;
    assign ptr_dec = ptr - 16'h0001;
    assign ptr_rel = ptr + {{10{offset[5]}}, offset};

    // addressing form decode; flags are never touched here
    always @* begin
        eff_addr = ptr;
        ptr_next = ptr;
        if (rel) begin
            eff_addr = ptr_rel;
            ptr_next = ptr;
        end else begin
            case (mode)
                `SMIE_MODE_PRE_INC: begin
                    eff_addr = ptr_inc;
                    ptr_next = ptr_inc;
                end
                `SMIE_MODE_PRE_DEC: begin
                    eff_addr = ptr_dec;
                    ptr_next = ptr_dec;
                end
                `SMIE_MODE_POST_INC: begin
                    eff_addr = ptr;
                    ptr_next = ptr_inc;
                end
                `SMIE_MODE_POST_DEC: begin
                    eff_addr = ptr;
                    ptr_next = ptr_dec;
                end
                default: begin
                    eff_addr = ptr;
                    ptr_next = ptr;
                end
            endcase
        end
    end
endmodule

// ### core/smie_exec.v
`timescale 1ns/1ps
`include "smie_defines.vh"

module smie_exec #(
    parameter MEM_AW = 12              // file memory address bits
) (
    input  wire       CLK,
    input  wire       RST_N,
    input  wire       OP_VALID,
    input  wire [2:0] OP_CODE,
    input  wire [6:0] FILE_ADDR,
    input  wire       DEST_SEL,
    input  wire       PTR_SEL,
    input  wire [1:0] PTR_MODE,
    input  wire       REL_FORM,
    input  wire [5:0] REL_OFFSET,
    input  wire [7:0] LITERAL,
    input  wire [3:0] REG_ADDR,
    input  wire [7:0] REG_WDATA,
    input  wire       REG_WR,
    input  wire       REG_RD,
    output reg  [7:0] REG_RDATA,
    output reg  [7:0] ACC,
    output reg  [4:0] BANK_SEL,
    output reg  [6:0] PAGE_LATCH,
    output reg        CARRY,
    output reg        ZERO,
    output reg        OP_DONE
);
    localparam MEM_DEPTH = 1 << MEM_AW;

    // zero test shared by every operation that updates the zero flag
    function zero_of;
        input [7:0] value;
        begin
            zero_of = (value == 8'h00);
        end
    endfunction

    // fold a sixteen-bit data address onto the implemented memory
    function [MEM_AW-1:0] mem_index;
        input [15:0] addr;
        begin
            mem_index = addr[MEM_AW-1:0];
        end
    endfunction

    // right shift with a zero entering the top bit
    function [7:0] shift_in_zero;
        input [7:0] value;
        begin
            shift_in_zero = {1'h0, value[7:1]};
        end
    endfunction

    reg  [1:0]  rst_sync_q;            // reset release synchroniser
    wire        rst_n_i;               // synchronised reset used everywhere else

    reg  [7:0]  file_mem [0:MEM_DEPTH-1]; // file register storage
    reg  [15:0] ptr0_q;                // indirect pointer 0
    reg  [15:0] ptr1_q;                // indirect pointer 1
    reg  [15:0] maddr_q;               // software memory window address

    wire [15:0] ptr_cur;               // pointer chosen by PTR_SEL
    wire [15:0] ind_eff;               // indirect effective address
    wire [15:0] ind_next;              // pointer after the indirect access

    // next-state values; the datapath process drives most, separate processes the address, operand, read data and status image
    reg  [15:0] file_addr_d;           // resolved address for file ops
    reg  [7:0]  file_val;              // operand read from the file
    reg  [7:0]  result_d;              // datapath result
    reg  [7:0]  acc_d;                 // next accumulator
    reg  [4:0]  bank_d;                // next bank select
    reg  [6:0]  page_d;                // next page latch
    reg         carry_d;               // next carry flag
    reg         zero_d;                // next zero flag
    reg         mem_we_d;              // operation writes the file
    reg  [15:0] ptr0_d;                // next pointer 0
    reg  [15:0] ptr1_d;                // next pointer 1
    reg  [15:0] maddr_d;               // next memory window address
    reg         bus_mem_we;            // software writes the file
    reg  [7:0]  rdata_d;               // read data for the next cycle
    reg  [7:0]  status_val;            // status register image

    // reset asserts at once and releases after two clean edges
    // the raw pin never reaches the state flops, so a release close to
    // a clock edge cannot leave half of the registers in reset
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'h1};
        end
    end
    assign rst_n_i = rst_sync_q[1];

    assign ptr_cur = PTR_SEL ? ptr1_q : ptr0_q;

    // one pointer unit serves both pointers; PTR_SEL picks the one
    // that is read and stepped
    smie_ptr_unit u_ptr (
        .ptr      (ptr_cur),
        .mode     (PTR_MODE),
        .rel      (REL_FORM),
        .offset   (REL_OFFSET),
        .eff_addr (ind_eff),
        .ptr_next (ind_next)
    );

    // direct addresses are bank-extended; windows redirect to a pointer
    // an indirect load never goes through the windows, so a pointer
    // cannot end up addressing through itself
    always @* begin
        if (FILE_ADDR == `SMIE_WINDOW0_ADDR) begin
            file_addr_d = ptr0_q;
        end else if (FILE_ADDR == `SMIE_WINDOW1_ADDR) begin
            file_addr_d = ptr1_q;
        end else begin
            file_addr_d = {4'h0, BANK_SEL, FILE_ADDR};
        end
    end

    // operand fetch: indirect load uses its own effective address
    // the storage is read without a clock so that every operation
    // finishes in the cycle in which it is taken
    always @* begin
        if (OP_CODE == `SMIE_OP_INDIRECT_LD) begin
            file_val = file_mem[mem_index(ind_eff)];
        end else begin
            file_val = file_mem[mem_index(file_addr_d)];
        end
    end

    // operation datapath; everything lands at the end of the cycle
    // defaults hold every register, so an idle cycle or a refused code
    // changes nothing but the done pulse
    always @* begin
        acc_d    = ACC;
        bank_d   = BANK_SEL;
        page_d   = PAGE_LATCH;
        carry_d  = CARRY;
        zero_d   = ZERO;
        mem_we_d = 1'h0;
        result_d = file_val;
        ptr0_d   = ptr0_q;
        ptr1_d   = ptr1_q;
        bus_mem_we = 1'h0;
        maddr_d  = maddr_q;
        if (OP_VALID) begin
            case (OP_CODE)
                `SMIE_OP_SHIFT_RIGHT: begin
                    result_d = shift_in_zero(file_val);
                    carry_d  = file_val[0];
                    zero_d   = zero_of(shift_in_zero(file_val));
                    if (DEST_SEL == `SMIE_DEST_ACC) begin
                        acc_d = shift_in_zero(file_val);
                    end else begin
                        mem_we_d = 1'h1;
                    end
                end
                `SMIE_OP_COPY_FILE: begin
                    zero_d = zero_of(file_val);
                    if (DEST_SEL == `SMIE_DEST_ACC) begin
                        acc_d = file_val;
                    end else begin
                        mem_we_d = 1'h1;
                    end
                end
                `SMIE_OP_INDIRECT_LD: begin
                    acc_d  = file_val;
                    zero_d = zero_of(file_val);
                    // pointer step leaves carry alone
                    if (PTR_SEL) begin
                        ptr1_d = ind_next;
                    end else begin
                        ptr0_d = ind_next;
                    end
                end
                `SMIE_OP_BANK_LIT: begin
                    bank_d = LITERAL[4:0];
                end
                `SMIE_OP_PAGE_LIT: begin
                    page_d = LITERAL[6:0];
                end
                `SMIE_OP_ACC_LIT: begin
                    acc_d = LITERAL;
                end
                default: begin
                    acc_d = ACC;
                end
            endcase
        end

        // software writes; an operation in the same cycle overrides all but the memory window ones
        // a register or pointer write that meets an operation is dropped, never merged; MADDR writes always land,
        // and an MDATA write is lost only to an operation that writes the file
        if (REG_WR) begin
            case (REG_ADDR)
                `SMIE_REG_ACC: begin
                    if (!OP_VALID) begin
                        acc_d = REG_WDATA;
                    end
                end
                `SMIE_REG_STATUS: begin
                    if (!OP_VALID) begin
                        carry_d = REG_WDATA[`SMIE_STAT_CARRY];
                        zero_d  = REG_WDATA[`SMIE_STAT_ZERO];
                    end
                end
                `SMIE_REG_BANK: begin
                    if (!OP_VALID) begin
                        bank_d = REG_WDATA[4:0];
                    end
                end
                `SMIE_REG_PAGE: begin
                    if (!OP_VALID) begin
                        page_d = REG_WDATA[6:0];
                    end
                end
                `SMIE_REG_PTR0_LO: begin
                    if (!OP_VALID) begin
                        ptr0_d[7:0] = REG_WDATA;
                    end
                end
                `SMIE_REG_PTR0_HI: begin
                    if (!OP_VALID) begin
                        ptr0_d[15:8] = REG_WDATA;
                    end
                end
                `SMIE_REG_PTR1_LO: begin
                    if (!OP_VALID) begin
                        ptr1_d[7:0] = REG_WDATA;
                    end
                end
                `SMIE_REG_PTR1_HI: begin
                    if (!OP_VALID) begin
                        ptr1_d[15:8] = REG_WDATA;
                    end
                end
                `SMIE_REG_MADDR_LO: begin
                    maddr_d[7:0] = REG_WDATA;
                end
                `SMIE_REG_MADDR_HI: begin
                    maddr_d[15:8] = REG_WDATA;
                end
                `SMIE_REG_MDATA: begin
                    // single write port: an operation write takes it
                    bus_mem_we = ~mem_we_d;
                end
                default: begin
                    bus_mem_we = 1'h0;
                end
            endcase
        end
    end

    // status image for software reads
    // bits other than carry and zero read as zero
    always @* begin
        status_val = 8'h00;
        status_val[`SMIE_STAT_CARRY] = CARRY;
        status_val[`SMIE_STAT_ZERO]  = ZERO;
    end

    // read mux; unmapped offsets answer zero
    // read data is masked outside the read slot so that a stale
    // value never looks like an answer
    always @* begin
        case (REG_ADDR)
            `SMIE_REG_ACC:      rdata_d = ACC;
            `SMIE_REG_STATUS:   rdata_d = status_val;
            `SMIE_REG_BANK:     rdata_d = {3'h0, BANK_SEL};
            `SMIE_REG_PAGE:     rdata_d = {1'h0, PAGE_LATCH};
            `SMIE_REG_PTR0_LO:  rdata_d = ptr0_q[7:0];
            `SMIE_REG_PTR0_HI:  rdata_d = ptr0_q[15:8];
            `SMIE_REG_PTR1_LO:  rdata_d = ptr1_q[7:0];
            `SMIE_REG_PTR1_HI:  rdata_d = ptr1_q[15:8];
            `SMIE_REG_MADDR_LO: rdata_d = maddr_q[7:0];
            `SMIE_REG_MADDR_HI: rdata_d = maddr_q[15:8];
            `SMIE_REG_MDATA:    rdata_d = file_mem[mem_index(maddr_q)];
            default:            rdata_d = 8'h00;
        endcase
        if (!REG_RD) begin
            rdata_d = 8'h00;
        end
    end

    // architectural state update at the end of the instruction cycle
    // pointers reset to zero, so a fresh core walks from address zero
    always @(posedge CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ACC        <= `SMIE_RST_ACC;
            BANK_SEL   <= `SMIE_RST_BANK;
            PAGE_LATCH <= `SMIE_RST_PAGE;
            CARRY      <= `SMIE_RST_FLAG;
            ZERO       <= `SMIE_RST_FLAG;
            ptr0_q     <= `SMIE_RST_PTR;
            ptr1_q     <= `SMIE_RST_PTR;
            maddr_q    <= `SMIE_RST_PTR;
            REG_RDATA  <= 8'h00;
            OP_DONE    <= 1'h0;
        end else begin
            ACC        <= acc_d;
            BANK_SEL   <= bank_d;
            PAGE_LATCH <= page_d;
            CARRY      <= carry_d;
            ZERO       <= zero_d;
            ptr0_q     <= ptr0_d;
            ptr1_q     <= ptr1_d;
            maddr_q    <= maddr_d;
            REG_RDATA  <= rdata_d;
            OP_DONE    <= OP_VALID;
        end
    end

    // file storage needs no reset; contents are software's business
    // the operation write owns the single port; a colliding software
    // write is lost, which software has to avoid
    always @(posedge CLK) begin
        if (OP_VALID && mem_we_d) begin
            file_mem[mem_index(file_addr_d)] <= result_d;
        end else if (bus_mem_we) begin
            file_mem[mem_index(maddr_q)] <= REG_WDATA;
        end
    end
endmodule

// ### bench/smie_dec_model.sv
`timescale 1ns/1ps
// decoder model: one operation word per cycle, launched just after a rising edge
module smie_dec_model (
    input  wire       clk,
    output reg        op_valid,
    output wire [2:0] op_code,
    output wire [6:0] file_addr,
    output wire       dest_sel,
    output wire       ptr_sel,
    output wire [1:0] ptr_mode,
    output wire       rel_form,
    output wire [5:0] rel_offset,
    output wire [7:0] literal
);
    reg [28:0] fld; // all qualifying fields of the word
    assign {op_code, file_addr, dest_sel, ptr_sel, ptr_mode, rel_form, rel_offset, literal} = fld;
    initial begin
        op_valid = 1'b0;
        fld = 29'h0;
    end
    // present one word for exactly one edge
    task issue(input [2:0] c, input [6:0] fa, input ds, input ps, input [1:0] md, input rl,
               input [5:0] of, input [7:0] l);
        begin
            @(posedge clk);
            op_valid <= 1'b1;
            fld <= {c, fa, ds, ps, md, rl, of, l};
        end
    endtask
    // idle cycle: fields flip so a stale word can never pass for a valid one
    task hold;
        begin
            @(posedge clk);
            op_valid <= 1'b0;
            fld <= ~fld;
        end
    endtask
endmodule

// ### bench/smie_exec_monitor.sv
`timescale 1ns/1ps
// checker on the operation and software ports
module smie_exec_monitor (
    input wire       CLK,
    input wire       RST_N,
    input wire       OP_VALID,
    input wire [2:0] OP_CODE,
    input wire       DEST_SEL,
    input wire [7:0] LITERAL,
    input wire       REG_RD,
    input wire [7:0] REG_RDATA,
    input wire [7:0] ACC,
    input wire [4:0] BANK_SEL,
    input wire [6:0] PAGE_LATCH,
    input wire       CARRY,
    input wire       ZERO,
    input wire       OP_DONE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    wire [7:0] hit = OP_VALID ? (8'h01 << OP_CODE) : 8'h00; // one-hot of the taken code
    a_done_pulse: assert property (OP_VALID |=> OP_DONE)
        else $error("done missing after op");
    a_done_cause: assert property (OP_DONE |-> $past(OP_VALID))
        else $error("done without op");
    a_acc_literal: assert property (hit[6] |=> ACC == $past(LITERAL) && $stable({CARRY, ZERO}))
        else $error("acc literal wrong");
    a_bank_literal: assert property (hit[4] |=> BANK_SEL == $past(LITERAL[4:0]) && $stable({CARRY, ZERO}))
        else $error("bank literal wrong");
    a_page_literal: assert property (hit[5] |=> PAGE_LATCH == $past(LITERAL[6:0]) && $stable({CARRY, ZERO}))
        else $error("page literal wrong");
    a_shift_acc: assert property (hit[1] && !DEST_SEL |=> !ACC[7] && ZERO == (ACC == 8'h00))
        else $error("shift into acc wrong");
    a_copy_zero: assert property (hit[2] && !DEST_SEL |=> ZERO == (ACC == 8'h00) && $stable(CARRY))
        else $error("copy zero flag wrong");
    a_ptr_flags: assert property (hit[3] |=> ZERO == (ACC == 8'h00) && $stable(CARRY))
        else $error("indirect flags wrong");
    a_file_dest: assert property ((hit[1] || hit[2]) && DEST_SEL |=> $stable(ACC))
        else $error("file destination touched acc");
    a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 8'h00)
        else $error("read data outside read slot");
endmodule

bind smie_exec smie_exec_monitor u_mon (
    .CLK(CLK), .RST_N(RST_N), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .DEST_SEL(DEST_SEL),
    .LITERAL(LITERAL), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ACC(ACC), .BANK_SEL(BANK_SEL),
    .PAGE_LATCH(PAGE_LATCH), .CARRY(CARRY), .ZERO(ZERO), .OP_DONE(OP_DONE)
);

// ### bench/smie_exec_tb.sv
`timescale 1ns/1ps
`include "smie_defines.vh"
// ops come through the decoder model, software accesses straight from here
module smie_exec_tb;
    reg         CLK = 1'b0;           // 40 MHz core clock
    reg         RST_N = 1'b0;         // raw reset, low active
    reg  [3:0]  REG_ADDR = 4'h0;
    reg  [7:0]  REG_WDATA = 8'h00;
    reg         REG_WR = 1'b0;
    reg         REG_RD = 1'b0;
    wire        OP_VALID, DEST_SEL, PTR_SEL, REL_FORM, CARRY, ZERO, OP_DONE;
    wire [2:0]  OP_CODE;
    wire [6:0]  FILE_ADDR, PAGE_LATCH;
    wire [1:0]  PTR_MODE;
    wire [5:0]  REL_OFFSET;
    wire [7:0]  LITERAL, REG_RDATA, ACC;
    wire [4:0]  BANK_SEL;
    integer     n_mismatch = 0;       // mismatches seen
    integer     tests_run = 0;        // comparisons made
    integer     i, k;
    reg  [21:0] eq[$];                // expected state, one note per op
    reg  [7:0]  rq[$];                // expected read data, one note per read
    reg         rd_d = 1'b0;          // a read was taken at the last edge
    reg  [7:0]  m_acc = 8'h00, v, r;  // model accumulator and scratch
    reg  [4:0]  m_bank = 5'h00;
    reg  [6:0]  m_page = 7'h00;
    reg         m_c = 1'b0, m_z = 1'b0;
    reg  [15:0] p, e;
    reg  [31:0] seed = 32'h00000F24;

    smie_exec #(.MEM_AW(12)) dut (.CLK(CLK), .RST_N(RST_N), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
        .FILE_ADDR(FILE_ADDR), .DEST_SEL(DEST_SEL), .PTR_SEL(PTR_SEL), .PTR_MODE(PTR_MODE),
        .REL_FORM(REL_FORM), .REL_OFFSET(REL_OFFSET), .LITERAL(LITERAL), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ACC(ACC),
        .BANK_SEL(BANK_SEL), .PAGE_LATCH(PAGE_LATCH), .CARRY(CARRY), .ZERO(ZERO), .OP_DONE(OP_DONE));
    smie_dec_model dec (.clk(CLK), .op_valid(OP_VALID), .op_code(OP_CODE), .file_addr(FILE_ADDR),
        .dest_sel(DEST_SEL), .ptr_sel(PTR_SEL), .ptr_mode(PTR_MODE), .rel_form(REL_FORM),
        .rel_offset(REL_OFFSET), .literal(LITERAL));

    always #12.5 CLK = ~CLK;

    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input [31:0] x, input [31:0] g);
        begin
            tests_run = tests_run + 1;
            if (x !== g) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch at %0t expected %h got %h", $time, x, g);
            end
        end
    endtask
    task report_and_stop;
        begin
            if (n_mismatch == 0 && tests_run > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // software access; the op port idles so the write is never dropped
    task sw(input w, input [3:0] a, input [7:0] d);
        begin
            dec.hold;
            REG_WR <= w;
            REG_RD <= !w;
            REG_ADDR <= a;
            REG_WDATA <= d;
            if (!w)
                rq.push_back(d);
        end
    endtask
    task mem(input w, input [15:0] a, input [7:0] d);
        begin
            sw(1'b1, `SMIE_REG_MADDR_LO, a[7:0]);
            sw(1'b1, `SMIE_REG_MADDR_HI, a[15:8]);
            sw(w, `SMIE_REG_MDATA, d);
        end
    endtask
    task ptr(input w, input s, input [15:0] a);
        begin
            sw(w, {2'b01, s, 1'b0}, a[7:0]);
            sw(w, {2'b01, s, 1'b1}, a[15:8]);
        end
    endtask
    // caller updates the model first; the note is the state after the op
    task op(input [2:0] c, input [6:0] fa, input ds, input ps, input [1:0] md, input rl,
            input [5:0] of, input [7:0] l);
        begin
            dec.issue(c, fa, ds, ps, md, rl, of, l);
            REG_WR <= 1'b0;
            REG_RD <= 1'b0;
            eq.push_back({m_acc, m_bank, m_page, m_c, m_z});
        end
    endtask

    // watcher: oldest note against what the ports show
    always @(posedge CLK)
        rd_d <= REG_RD;
    always @(negedge CLK) begin
        if (OP_DONE === 1'b1)
            chk(eq.pop_front(), {ACC, BANK_SEL, PAGE_LATCH, CARRY, ZERO});
        if (rd_d === 1'b1)
            chk(rq.pop_front(), REG_RDATA);
    end

    // run takes under two hundred cycles; this leaves a wide margin
    initial begin
        #(25 * 5000);
        n_mismatch = n_mismatch + 1;
        report_and_stop;
    end

    initial begin
        repeat (20) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge CLK);
        sw(1'b0, `SMIE_REG_STATUS, 8'h00);
        ptr(1'b0, 1'b1, 16'h0000);
        // back-to-back literal loads with random operands
        for (i = 0; i < 8; i = i + 1) begin
            seed = lfsr(seed);
            v = seed[7:0];
            m_acc = v;
            op(`SMIE_OP_ACC_LIT, 7'h00, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00, v);
            m_bank = v[4:0];
            op(`SMIE_OP_BANK_LIT, 7'h00, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00, v);
            m_page = v[6:0];
            op(`SMIE_OP_PAGE_LIT, 7'h00, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00, v);
        end
        m_bank = 5'h00;
        op(`SMIE_OP_BANK_LIT, 7'h00, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00, 8'hE0);
        // shift and copy over zero, lsb-only, msb-only and random sources
        for (i = 0; i < 4; i = i + 1) begin
            seed = lfsr(seed);
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'h80 : seed[7:0];
            r = {1'b0, v[7:1]};
            mem(1'b1, 16'h0020 + i, v);
            m_z = (v == 8'h00);
            op(`SMIE_OP_COPY_FILE, 7'h20 + i, 1'b1, 1'b0, 2'h0, 1'b0, 6'h00, 8'h00);
            m_acc = r;
            m_c = v[0];
            m_z = (r == 8'h00);
            op(`SMIE_OP_SHIFT_RIGHT, 7'h20 + i, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00, 8'h00);
            op(`SMIE_OP_SHIFT_RIGHT, 7'h20 + i, 1'b1, 1'b0, 2'h0, 1'b0, 6'h00, 8'h00);
            mem(1'b0, 16'h0020 + i, r);
            m_acc = ~r;
            op(`SMIE_OP_ACC_LIT, 7'h00, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00, ~r);
            m_acc = r;
            op(`SMIE_OP_COPY_FILE, 7'h20 + i, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00, 8'h00);
        end
        // every update code on both pointers, each at the end of the range where it wraps
        mem(1'b1, 16'h0000, 8'h00);
        mem(1'b1, 16'h0FFF, 8'hC3);
        for (k = 0; k < 8; k = k + 1) begin
            p = k[0] ? 16'h0000 : 16'hFFFF;
            e = k[1] ? p : (k[0] ? p - 16'h0001 : p + 16'h0001);
            ptr(1'b1, k[2], p);
            m_acc = e[0] ? 8'hC3 : 8'h00;
            m_z = !e[0];
            op(`SMIE_OP_INDIRECT_LD, 7'h00, 1'b0, k[2], k[1:0], 1'b0, 6'h00, 8'h00);
            ptr(1'b0, k[2], k[0] ? p - 16'h0001 : p + 16'h0001);
        end
        // relative form at both offset limits, pointer left alone
        ptr(1'b1, 1'b1, 16'h0100);
        for (k = 0; k < 2; k = k + 1) begin
            e = k[0] ? 16'h011F : 16'h00E0;
            seed = lfsr(seed);
            mem(1'b1, e, seed[7:0]);
            m_acc = seed[7:0];
            m_z = (seed[7:0] == 8'h00);
            op(`SMIE_OP_INDIRECT_LD, 7'h00, 1'b0, 1'b1, k[1:0], 1'b1, k[0] ? 6'h1F : 6'h20, 8'h00);
            ptr(1'b0, 1'b1, 16'h0100);
        end
        // window addresses go through the matching pointer
        ptr(1'b1, 1'b0, 16'h0123);
        mem(1'b1, 16'h0123, 8'h3C);
        mem(1'b1, 16'h0100, 8'h00);
        m_acc = 8'h3C;
        m_z = 1'b0;
        op(`SMIE_OP_COPY_FILE, `SMIE_WINDOW0_ADDR, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00, 8'h00);
        m_acc = 8'h00;
        m_z = 1'b1;
        op(`SMIE_OP_COPY_FILE, `SMIE_WINDOW1_ADDR, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00, 8'h00);
        ptr(1'b0, 1'b0, 16'h0123);
        // refused codes leave all state alone
        op(`SMIE_OP_NONE, 7'h00, 1'b1, 1'b0, 2'h0, 1'b0, 6'h00, 8'hFF);
        op(3'h7, 7'h00, 1'b1, 1'b0, 2'h0, 1'b0, 6'h00, 8'hFF);
        dec.hold;
        repeat (3) @(posedge CLK);
        chk(32'h0, eq.size() + rq.size());
        report_and_stop;
    end
endmodule
